// ===== hw/imp_regs.vh
// Register offsets, field positions and reset values of the interrupt mask/poll/eoi block
`ifndef IMP_REGS_VH
`define IMP_REGS_VH
`define IMP_OFS_VECTOR 8'h20
`define IMP_OFS_EOI 8'h22
`define IMP_OFS_POLL 8'h24
`define IMP_OFS_POLL_STATUS_PEEK 8'h26
`define IMP_OFS_PRIMASK 8'h2A
`define IMP_OFS_IN_SERVICE_REG 8'h2C
`define IMP_OFS_MASK 8'h28
`define IMP_OFS_REQUEST 8'h2E
`define IMP_MASK_RST_MASTER 16'h07FD
`define IMP_MASK_RST_SLAVE 16'h003D
`define IMP_MASK_VALID_MASTER 16'h07FD
`define IMP_MASK_VALID_SLAVE 16'h003D
`define IMP_PRI_RST 3'h7
`define IMP_PEND_BIT 15
`define IMP_NONSPECIFIC_SELECT_BIT 15
`define IMP_VEC_LO 3
`define IMP_VEC_HI 7
`define IMP_NSRC 11
`define IMP_MASTER_TYPE_BASE 5'h08
`define IMP_ZERO16 16'h0000
`endif

// ===== hw/imp_ctrl.v
// Interrupt mask, poll, poll-status, end-of-interrupt and vector registers
// Functional notes
// R1: Mask register write equals per-source mask write
// R2: Mask bit one blocks request, zero passes
// R3: Master mask resets to 07FD, master layout
// R4: Slave mask resets to 003D, slave layout
// R5: Slave mask reads back per-source mask bits
// R6: Poll-status read has no side effect
// R7: Poll read acknowledges highest pending interrupt
// R8: Poll bit 15 flags a pending interrupt
// R9: Poll bits 4-0 give pending type
// R10: Poll registers read-only, writes ignored
// R11: Master end-of-interrupt write clears in-service flags
// R12: Bit 15 nonspecific, else specific type clear
// R13: Handler writes end-of-interrupt before returning
// R14: Software should prefer specific end-of-interrupt
// R15: Slave end-of-interrupt clears level in bits 2-0
// R16: End-of-interrupt register is write-only
// R17: Slave vector holds type upper five bits
// R18: Vector offset is type times four
// R19: Priority above threshold is blocked
// R20: Taken interrupt sets in-service until cleared
// R21: Reserved bits read zero, writes ignored
`timescale 1ns/1ps
`include "imp_regs.vh"
module imp_ctrl
(
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // Mode strap, sampled after reset release
    input wire slave_mode_in,
    // Wishbone slave
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [7:0] wb_adr_in,
    input wire [1:0] wb_sel_in,
    input wire [15:0] wb_dat_in,
    output reg [15:0] wb_dat_out,
    output reg wb_ack_out,
    // Sources, one bit per mask position; priority three bits per source
    input wire [15:0] pending_flag_in,
    input wire [23:0] source_priority_in,
    input wire [15:0] ctl_mask_set_in,
    input wire [15:0] ctl_mask_clr_in,
    // Processor acknowledge
    input wire int_ack_in,
    output reg int_req_out,
    output reg [7:0] int_type_out,
    output reg [9:0] vector_offset_out,
    // Mask and in-service views
    output reg [15:0] source_mask_out,
    output reg [15:0] in_service_out
);

// ----------------------------------------------------------------
// State
// ----------------------------------------------------------------
reg [1:0] rst_sync_reg;
reg mode_sync_a_reg;
reg mode_sync_b_reg;
reg slave_reg;
reg strap_done_reg;
reg [15:0] source_mask_reg;
reg [2:0] priority_threshold_reg;
reg [15:0] in_service_reg;
reg [4:0] vector_type_upper_reg;
reg [15:0] pend_a_reg;
reg [15:0] pend_b_reg;
reg [15:0] mask_next;
reg [15:0] in_service_next;
reg [15:0] rd_data;
reg [15:0] clr_bits;
reg [15:0] set_bits;
reg [2:0] eoi_pri;
integer i;
integer j;

wire bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
wire wr_req = bus_req & wb_we_in & (&wb_sel_in);
wire rd_req = bus_req & ~wb_we_in;
wire [15:0] valid_mask = slave_reg ? `IMP_MASK_VALID_SLAVE : `IMP_MASK_VALID_MASTER;

// ----------------------------------------------------------------
// Arbitration helpers
// ----------------------------------------------------------------
function [2:0] pri_of;
    input [23:0] pri;
    input [3:0] idx;
    begin
        pri_of = pri[idx * 3 +: 3];
    end
endfunction

// Eligible: pending, unmasked, within threshold, and not itself in service
reg [15:0] eligible;
reg found;
reg [3:0] win_idx;
reg [2:0] win_pri;
always @*
begin
    eligible = `IMP_ZERO16;
    found = 1'b0;
    win_idx = 4'h0;
    win_pri = 3'h7;
    for (i = 0; i < `IMP_NSRC; i = i + 1)
    begin
        eligible[i] = pend_b_reg[i] & ~source_mask_reg[i] & valid_mask[i] // see R2
            & (pri_of(source_priority_in, i[3:0]) <= priority_threshold_reg) // see R19
            & ~in_service_reg[i];
        if (eligible[i] && (!found || pri_of(source_priority_in, i[3:0]) < win_pri))
        begin
            found = 1'b1;
            win_idx = i[3:0];
            win_pri = pri_of(source_priority_in, i[3:0]);
        end
    end
end

// Master type follows source index, slave type takes level from priority
wire [4:0] poll_type = slave_reg ? {2'b00, win_pri} : (`IMP_MASTER_TYPE_BASE + {1'b0, win_idx});
wire [15:0] poll_word = found ? {1'b1, 10'h000, poll_type} : `IMP_ZERO16; // see R8, R9, R21
wire [7:0] cpu_type = slave_reg ? {vector_type_upper_reg, win_pri} : {3'h0, poll_type}; // see R17

// ----------------------------------------------------------------
// Read mux
// ----------------------------------------------------------------
always @*
begin
    rd_data = `IMP_ZERO16;
    case (wb_adr_in)
        `IMP_OFS_MASK: rd_data = source_mask_reg & valid_mask; // see R5, R21
        `IMP_OFS_POLL: rd_data = poll_word;
        `IMP_OFS_POLL_STATUS_PEEK: rd_data = poll_word; // see R6
        `IMP_OFS_PRIMASK: rd_data = {13'h0000, priority_threshold_reg};
        `IMP_OFS_IN_SERVICE_REG: rd_data = in_service_reg;
        `IMP_OFS_REQUEST: rd_data = pend_b_reg & valid_mask;
        `IMP_OFS_VECTOR: rd_data = slave_reg ? {8'h00, vector_type_upper_reg, 3'h0} : `IMP_ZERO16;
        default: rd_data = `IMP_ZERO16; // End-of-interrupt reads zero, see R16
    endcase
end

// ----------------------------------------------------------------
// Mask and in-service next state
// ----------------------------------------------------------------
always @*
begin
    mask_next = source_mask_reg;
    eoi_pri = 3'h7;
    if (wr_req && wb_adr_in == `IMP_OFS_MASK)
        mask_next = wb_dat_in & valid_mask; // see R1, R21
    // Per-source control writes land in the same bits so both views agree
    mask_next = (mask_next | ctl_mask_set_in) & ~ctl_mask_clr_in & valid_mask; // see R1, R5
    clr_bits = `IMP_ZERO16;
    if (wr_req && wb_adr_in == `IMP_OFS_EOI)
    begin
        if (slave_reg)
        begin
            for (j = 0; j < `IMP_NSRC; j = j + 1)
                if (valid_mask[j] && pri_of(source_priority_in, j[3:0]) == wb_dat_in[2:0])
                    clr_bits[j] = 1'b1; // see R15
        end
        else if (wb_dat_in[`IMP_NONSPECIFIC_SELECT_BIT])
        begin
            // Nonspecific: clear every in-service flag at the highest in-service priority level
            for (j = 0; j < `IMP_NSRC; j = j + 1)
                if (in_service_reg[j] && pri_of(source_priority_in, j[3:0]) <= eoi_pri)
                    eoi_pri = pri_of(source_priority_in, j[3:0]);
            for (j = 0; j < `IMP_NSRC; j = j + 1)
                if (in_service_reg[j] && pri_of(source_priority_in, j[3:0]) == eoi_pri)
                    clr_bits[j] = 1'b1; // see R11, R12
        end
        else
        begin
            for (j = 0; j < `IMP_NSRC; j = j + 1)
                if (wb_dat_in[4:0] == (`IMP_MASTER_TYPE_BASE + j[4:0]))
                    clr_bits[j] = 1'b1; // see R12
        end
    end
    set_bits = `IMP_ZERO16;
    // Processor acknowledge or a poll read takes the winner; poll-status does not
    if (found && (int_ack_in || (rd_req && wb_adr_in == `IMP_OFS_POLL))) // see R7, R6
        set_bits[win_idx] = 1'b1; // see R20
    // Set wins over a clear in the same cycle
    in_service_next = (in_service_reg & ~clr_bits) | set_bits;
end

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
always @(posedge clk_in or negedge rst_n_in)
begin
    if (!rst_n_in)
    begin
        mode_sync_a_reg <= 1'b0;
        mode_sync_b_reg <= 1'b0;
        slave_reg <= 1'b0;
        strap_done_reg <= 1'b0;
        rst_sync_reg <= 2'b00;
        source_mask_reg <= `IMP_MASK_RST_MASTER; // see R3
        priority_threshold_reg <= `IMP_PRI_RST; // see R19
        in_service_reg <= `IMP_ZERO16;
        vector_type_upper_reg <= 5'h00;
        pend_a_reg <= `IMP_ZERO16;
        pend_b_reg <= `IMP_ZERO16;
        wb_ack_out <= 1'b0;
        wb_dat_out <= `IMP_ZERO16;
        int_req_out <= 1'b0;
        int_type_out <= 8'h00;
        vector_offset_out <= 10'h000;
        source_mask_out <= `IMP_MASK_RST_MASTER;
        in_service_out <= `IMP_ZERO16;
    end
    else
    begin
        mode_sync_a_reg <= slave_mode_in;
        mode_sync_b_reg <= mode_sync_a_reg;
        pend_a_reg <= pending_flag_in;
        pend_b_reg <= pend_a_reg;
        rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        if (!strap_done_reg && rst_sync_reg[1])
        begin
            // Mode is caught once; the mask takes the reset value of that mode
            strap_done_reg <= 1'b1;
            slave_reg <= mode_sync_b_reg;
            source_mask_reg <= mode_sync_b_reg ? `IMP_MASK_RST_SLAVE : `IMP_MASK_RST_MASTER; // see R3, R4
        end
        else
            source_mask_reg <= mask_next;
        in_service_reg <= in_service_next;
        if (wr_req && wb_adr_in == `IMP_OFS_PRIMASK)
            priority_threshold_reg <= wb_dat_in[2:0];
        if (wr_req && wb_adr_in == `IMP_OFS_VECTOR && slave_reg)
            vector_type_upper_reg <= wb_dat_in[`IMP_VEC_HI:`IMP_VEC_LO]; // see R17
        // Poll, poll-status, in-service and request writes fall through, see R10
        wb_ack_out <= bus_req;
        wb_dat_out <= rd_req ? rd_data : `IMP_ZERO16;
        int_req_out <= found;
        int_type_out <= cpu_type;
        vector_offset_out <= {cpu_type, 2'b00}; // see R18
        source_mask_out <= source_mask_reg;
        in_service_out <= in_service_reg;
    end
end

endmodule

// ===== dv/imp_ctrl_sva.sv
// Checker for the interrupt mask, poll and end-of-interrupt block
`timescale 1ns/1ps
module imp_ctrl_sva (
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // Bus and interrupt ports
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire [15:0] wb_dat_out,
    input wire wb_ack_out,
    input wire [15:0] pending_flag_in,
    input wire [15:0] ctl_mask_set_in,
    input wire int_ack_in,
    input wire int_req_out,
    input wire [7:0] int_type_out,
    input wire [9:0] vector_offset_out,
    input wire [15:0] source_mask_out,
    input wire [15:0] in_service_out
);
    // ----
    // Properties
    // ----
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_take; wb_cyc_in && wb_stb_in && !wb_ack_out; endsequence
    // Five quiet cycles cover the two-stage input sync
    sequence s_quiet; (pending_flag_in & ~source_mask_out) == 16'h0000 [*5]; endsequence
    property p_ack_once; s_take |=> wb_ack_out ##1 !wb_ack_out; endproperty
    property p_dat_idle; !wb_ack_out |-> wb_dat_out == 16'h0000; endproperty
    property p_offset; vector_offset_out == {int_type_out, 2'b00}; endproperty
    property p_mask_rsv; (source_mask_out & 16'hF802) == 16'h0000; endproperty
    property p_mask_set; ctl_mask_set_in[2] |-> ##[1:3] source_mask_out[2]; endproperty
    property p_blocked; s_quiet |-> !int_req_out; endproperty
    property p_ack_serv; int_ack_in && int_req_out |-> ##[1:3] in_service_out != 16'h0000;
    endproperty
    property p_rst_mask;
        @(posedge clk_in) disable iff (1'b0) !rst_n_in |-> source_mask_out == 16'h07FD;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack not one cycle");
    a_dat_idle: assert property (p_dat_idle) else $error("data outside ack");
    a_offset: assert property (p_offset) else $error("offset not type x4");
    a_mask_rsv: assert property (p_mask_rsv) else $error("reserved mask bit");
    a_mask_set: assert property (p_mask_set) else $error("mask set lost");
    a_blocked: assert property (p_blocked) else $error("masked request passed");
    a_ack_serv: assert property (p_ack_serv) else $error("no in-service bit");
    a_rst_mask: assert property (p_rst_mask) else $error("mask reset value");
endmodule
bind imp_ctrl imp_ctrl_sva imp_ctrl_sva_inst (.*);

// ===== dv/imp_cpu_model.sv
// Processor core model that takes offered interrupts
`timescale 1ns/1ps
module imp_cpu_model (
    input wire clk_in,
    input wire rst_n_in,
    input wire enable_in,
    input wire [3:0] delay_in,
    input wire int_req_in,
    output reg int_ack_out
);
    reg [3:0] wait_reg;
    reg done_reg;
    // Take once, then wait for the request to drop so a stale one is not taken twice
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            int_ack_out <= 1'b0;
            wait_reg <= 4'h0;
            done_reg <= 1'b0;
        end
        else
        begin
            int_ack_out <= 1'b0;
            if (!int_req_in || !enable_in)
            begin
                wait_reg <= 4'h0;
                done_reg <= 1'b0;
            end
            else if (!done_reg && wait_reg == delay_in)
            begin
                int_ack_out <= 1'b1;
                done_reg <= 1'b1;
            end
            else if (!done_reg)
                wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule

// ===== dv/imp_ctrl_test.sv
// Self-checking bench for the interrupt mask, poll and end-of-interrupt block
`timescale 1ns/1ps
module imp_ctrl_test;
    reg clk_in = 0, rst_n_in = 1, slave = 0, cyc = 0, stb = 0, we = 0, en = 0;
    reg [7:0] adr = 8'h00;
    reg [15:0] dat = 16'h0000, pend = 16'h0000, mset = 16'h0000, mclr = 16'h0000, q, r;
    reg [23:0] prio = 24'h000000;
    reg [3:0] dly = 4'h0;
    wire ack, req, iack;
    wire [15:0] dout, mask, serv;
    wire [7:0] itype;
    wire [9:0] voff;
    integer fail_count = 0, compares = 0, n;
    imp_ctrl imp_ctrl_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .slave_mode_in(slave),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(2'h3),
        .wb_dat_in(dat), .wb_dat_out(dout), .wb_ack_out(ack), .pending_flag_in(pend),
        .source_priority_in(prio), .ctl_mask_set_in(mset), .ctl_mask_clr_in(mclr),
        .int_ack_in(iack), .int_req_out(req), .int_type_out(itype),
        .vector_offset_out(voff), .source_mask_out(mask), .in_service_out(serv));
    imp_cpu_model imp_cpu_model_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .enable_in(en),
        .delay_in(dly), .int_req_in(req), .int_ack_out(iack));
    // ----
    // Tasks
    // ----
    initial forever #10 clk_in = ~clk_in;
    task end_of_test;
    begin
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask
    task check(input string nm, input [15:0] e, input [15:0] g);
    begin
        compares = compares + 1;
        if (g !== e)
        begin
            fail_count = fail_count + 1;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    end
    endtask
    // Request held until ack is sampled; timeout closes the run
    task bus(input w, input [7:0] a, input [15:0] d);
    begin
        @(posedge clk_in);
        cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
        n = 0;
        do begin @(posedge clk_in); n = n + 1; end while (ack !== 1'b1 && n < 20);
        q = dout; cyc <= 0; stb <= 0; we <= 0;
        if (n >= 20) begin fail_count = fail_count + 1; end_of_test; end
    end
    endtask
    task rc(input [7:0] a, input [15:0] e, input string nm);
    begin
        bus(0, a, 16'h0000);
        check(nm, e, q);
    end
    endtask
    task do_reset;
    begin
        rst_n_in <= 0; repeat (6) @(posedge clk_in);
        rst_n_in <= 1; repeat (8) @(posedge clk_in);
    end
    endtask
    // ----
    // Scenarios
    // ----
    initial
    begin
        n = $urandom(93484);
        do_reset;
        rc(8'h28, 16'h07FD, "mask_rst");
        rc(8'h2A, 16'h0007, "pri_rst");
        r = $urandom;
        bus(1, 8'h28, r);
        rc(8'h28, r & 16'h07FD, "mask_rw");
        bus(1, 8'h28, 16'h0000);
        rc(8'h30, 16'h0000, "unmapped");
        $display("test regs done");
        prio <= 24'h003040; pend <= 16'h0014; repeat (6) @(posedge clk_in);
        rc(8'h26, 16'h800A, "poll_status_peek");
        bus(1, 8'h24, 16'hFFFF);
        rc(8'h26, 16'h800A, "poll_status_peek_ro");
        rc(8'h24, 16'h800A, "poll");
        rc(8'h26, 16'h800C, "poll_next");
        rc(8'h2C, 16'h0004, "in_service_reg");
        bus(1, 8'h22, 16'h000A);
        rc(8'h2C, 16'h0000, "eoi_spec");
        rc(8'h24, 16'h800A, "poll2");
        bus(1, 8'h22, 16'h8000);
        rc(8'h2C, 16'h0000, "eoi_nonspecific_select");
        bus(1, 8'h2A, 16'h0000); repeat (3) @(posedge clk_in);
        check("pri_block", 16'h0000, {15'h0000, req});
        bus(1, 8'h2A, 16'h0007);
        $display("test poll done");
        pend <= 16'h0004; dly <= $urandom % 8; en <= 1; n = 0;
        while (serv !== 16'h0004 && n < 40) begin @(posedge clk_in); n = n + 1; end
        en <= 0;
        check("cpu_take", 16'h0004, serv);
        bus(1, 8'h22, 16'h000A);
        mset <= 16'h0004; @(posedge clk_in); mset <= 16'h0000; repeat (3) @(posedge clk_in);
        rc(8'h28, 16'h0004, "mask_set");
        $display("test cpu done");
        slave <= 1; pend <= 16'h0000; do_reset;
        rc(8'h28, 16'h003D, "smask_rst");
        mclr <= 16'h0004; @(posedge clk_in); mclr <= 16'h0000; repeat (3) @(posedge clk_in);
        rc(8'h28, 16'h0039, "smask_view");
        bus(1, 8'h20, 16'hFFFF);
        rc(8'h20, 16'h00F8, "vector");
        rc(8'h22, 16'h0000, "eoi_wo");
        bus(1, 8'h28, 16'h0000); prio <= 24'h000005; pend <= 16'h0001;
        repeat (6) @(posedge clk_in);
        check("s_type", 16'h00FD, {8'h00, itype});
        check("s_voff", 16'h03F4, {6'h00, voff});
        bus(0, 8'h24, 16'h0000);
        rc(8'h2C, 16'h0001, "s_serv");
        bus(1, 8'h22, 16'h0005);
        rc(8'h2C, 16'h0000, "s_eoi");
        $display("test slave done");
        end_of_test;
    end
endmodule
